// ==== src/wiper_defines.vh ====
`ifndef WIPER_DEFINES_VH
`define WIPER_DEFINES_VH
// ****************************************
// Register map and reset values
// ****************************************
`define WIPER_REG_OFFSET 8'h00
`define WIPER_RESET 7'h40
`define WIPER_WIDTH 7
`define WIPER_TAPS 128
// Device type identifier, value is arbitrary
`define DEVICE_ID 7'h2A
// ****************************************
// Byte field positions
// ****************************************
`define DIR_BIT 0
`define ID_MSB 7
`define ID_LSB 1
`define DATA_DISCARD_BIT 7
`endif

// ==== src/tap_decoder.v ====
`timescale 1ns/10ps
`default_nettype none
`include "wiper_defines.vh"
module tap_decoder (
	// Position code
	input wire [6:0] position,
	// One-of-128 tap select
	output wire [127:0] tap_select
);
	genvar i;
	generate
		for (i = 0; i < `WIPER_TAPS; i = i + 1) begin : g_tap
			assign tap_select[i] = ({25'h000_0000, position} == i);
		end
	endgenerate
endmodule
`default_nettype wire

// ==== src/i2c_wiper_position_register.v ====
// Behaviour
// - Hold a 7-bit position and decode it to one of 128 tap switches.
// - Position resets to mid-scale 40h and is not retained.
// - Drop the top bit of written data; reads return it as zero first.
// - Write is address, index 00h, data; all three bytes acknowledged.
// - After the third write byte the position updates and taps follow.
// - Read is address write, index 00h, repeated start, address read.
// - Acknowledge the three received bytes, then drive the position byte.
// - Codes map linearly, code 0 one end, code 127 the other.
// - Last address bit is direction: one reads, zero writes.
// - Answer only a matching identifier; otherwise stay off the bus.
// - On master no-acknowledge stop driving and wait for stop.
`timescale 1ns/10ps
`default_nettype none
`include "wiper_defines.vh"
module i2c_wiper_position_register (
	// Clock, reset, enable
	input wire clk,
	input wire nrst,
	input wire clk_en,
	// I2C pins
	input wire scl_in,
	input wire sda_in,
	output wire sda_out,
	output wire sda_oe_n,
	// Analog array
	output wire [127:0] tap_select,
	output reg [6:0] wiper_position_register
);
	// ****************************************
	// States
	// ****************************************
	localparam [5:0] S_IDLE = 6'b000001;
	localparam [5:0] S_RECV = 6'b000010;
	localparam [5:0] S_ACK = 6'b000100;
	localparam [5:0] S_SEND = 6'b001000;
	localparam [5:0] S_MACK = 6'b010000;
	localparam [5:0] S_WAIT = 6'b100000;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	reg scl_s1_r, scl_s2_r, scl_d_r;
	reg sda_s1_r, sda_s2_r, sda_d_r;
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			scl_s1_r <= 1'b1;
			scl_s2_r <= 1'b1;
			scl_d_r <= 1'b1;
			sda_s1_r <= 1'b1;
			sda_s2_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else if (clk_en) begin
			scl_s1_r <= scl_in;
			scl_s2_r <= scl_s1_r;
			scl_d_r <= scl_s2_r;
			sda_s1_r <= sda_in;
			sda_s2_r <= sda_s1_r;
			sda_d_r <= sda_s2_r;
		end
	end
	wire scl_rise = scl_s2_r & ~scl_d_r;
	wire scl_fall = ~scl_s2_r & scl_d_r;
	wire start_det = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
	wire stop_det = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;

	// ****************************************
	// Protocol engine
	// ****************************************
	reg [5:0] state_r, state_nxt;
	reg [7:0] shift_r, shift_nxt;
	reg [3:0] bit_cnt_r, bit_cnt_nxt;
	// Byte index within frame: 0 address, 1 index, 2 data
	reg [1:0] byte_idx_r, byte_idx_nxt;
	reg ack_ok_r, ack_ok_nxt;
	reg reading_r, reading_nxt;
	reg index_ok_r, index_ok_nxt;
	reg drive_low_r, drive_low_nxt;
	reg [6:0] wiper_nxt;

	always @* begin
		state_nxt = state_r;
		shift_nxt = shift_r;
		bit_cnt_nxt = bit_cnt_r;
		byte_idx_nxt = byte_idx_r;
		ack_ok_nxt = ack_ok_r;
		reading_nxt = reading_r;
		index_ok_nxt = index_ok_r;
		drive_low_nxt = drive_low_r;
		wiper_nxt = wiper_position_register;
		if (stop_det) begin
			state_nxt = S_IDLE;
			drive_low_nxt = 1'b0;
		end else if (start_det) begin
			// Repeated start keeps the index state for the read
			state_nxt = S_RECV;
			bit_cnt_nxt = 4'd0;
			byte_idx_nxt = 2'd0;
			drive_low_nxt = 1'b0;
		end else begin
			case (state_r)
				S_IDLE: begin
					index_ok_nxt = 1'b0;
				end
				S_RECV: begin
					if (scl_rise) begin
						shift_nxt = {shift_r[6:0], sda_s2_r};
						bit_cnt_nxt = bit_cnt_r + 4'd1;
					end else if (scl_fall && bit_cnt_r == 4'd8) begin
						ack_ok_nxt = 1'b0;
						reading_nxt = 1'b0;
						case (byte_idx_r)
							2'd0: begin
								if (shift_r[`ID_MSB:`ID_LSB] == `DEVICE_ID) begin
									ack_ok_nxt = 1'b1;
									reading_nxt = shift_r[`DIR_BIT];
								end
							end
							2'd1: begin
								ack_ok_nxt = (shift_r == `WIPER_REG_OFFSET);
								index_ok_nxt = (shift_r == `WIPER_REG_OFFSET);
							end
							default: begin
								ack_ok_nxt = index_ok_r;
								if (index_ok_r) begin
									wiper_nxt = shift_r[6:0];
								end
							end
						endcase
						state_nxt = S_ACK;
						drive_low_nxt = 1'b1;
						if (byte_idx_r == 2'd0 && shift_r[`ID_MSB:`ID_LSB] != `DEVICE_ID) begin
							drive_low_nxt = 1'b0;
						end
						if (byte_idx_r == 2'd1 && shift_r != `WIPER_REG_OFFSET) begin
							drive_low_nxt = 1'b0;
						end
						if (byte_idx_r == 2'd2 && !index_ok_r) begin
							drive_low_nxt = 1'b0;
						end
					end
				end
				S_ACK: begin
					if (scl_fall) begin
						bit_cnt_nxt = 4'd0;
						if (!ack_ok_r) begin
							state_nxt = S_WAIT;
							drive_low_nxt = 1'b0;
						end else if (reading_r && byte_idx_r == 2'd0) begin
							state_nxt = S_SEND;
							shift_nxt = {1'b0, wiper_position_register};
							drive_low_nxt = 1'b1;
						end else begin
							state_nxt = (byte_idx_r == 2'd2) ? S_WAIT : S_RECV;
							byte_idx_nxt = byte_idx_r + 2'd1;
							drive_low_nxt = 1'b0;
						end
					end
				end
				S_SEND: begin
					if (bit_cnt_r == 4'd0) begin
						drive_low_nxt = ~shift_r[7];
					end
					if (scl_fall) begin
						bit_cnt_nxt = bit_cnt_r + 4'd1;
						shift_nxt = {shift_r[6:0], 1'b0};
						drive_low_nxt = ~shift_r[6];
						if (bit_cnt_r == 4'd7) begin
							state_nxt = S_MACK;
							drive_low_nxt = 1'b0;
						end
					end
				end
				S_MACK: begin
					if (scl_rise && sda_s2_r) begin
						state_nxt = S_WAIT;
					end else if (scl_fall) begin
						// Acknowledged: restart only after the slot clock falls,
						// else that fall would be counted as the first data bit
						state_nxt = S_SEND;
						bit_cnt_nxt = 4'd0;
						shift_nxt = {1'b0, wiper_position_register};
						drive_low_nxt = 1'b1;
					end
				end
				S_WAIT: begin
					drive_low_nxt = 1'b0;
				end
				default: begin
					state_nxt = S_IDLE;
					drive_low_nxt = 1'b0;
				end
			endcase
		end
	end

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_r <= S_IDLE;
			shift_r <= 8'h00;
			bit_cnt_r <= 4'd0;
			byte_idx_r <= 2'd0;
			ack_ok_r <= 1'b0;
			reading_r <= 1'b0;
			index_ok_r <= 1'b0;
			drive_low_r <= 1'b0;
			wiper_position_register <= `WIPER_RESET;
		end else if (clk_en) begin
			state_r <= state_nxt;
			shift_r <= shift_nxt;
			bit_cnt_r <= bit_cnt_nxt;
			byte_idx_r <= byte_idx_nxt;
			ack_ok_r <= ack_ok_nxt;
			reading_r <= reading_nxt;
			index_ok_r <= index_ok_nxt;
			drive_low_r <= drive_low_nxt;
			wiper_position_register <= wiper_nxt;
		end
	end

	// Open drain: only ever pull low
	assign sda_out = 1'b0;
	assign sda_oe_n = ~drive_low_r;

	tap_decoder u_tap_decoder (
		.position(wiper_position_register),
		.tap_select(tap_select)
	);
endmodule
`default_nettype wire

// ==== testbench/wiper_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
module wiper_sva (
	// Clock domain
	input wire clk,
	input wire nrst,
	input wire clk_en,
	// Bus and array
	input wire scl_in,
	input wire sda_out,
	input wire sda_oe_n,
	input wire [127:0] tap_select,
	input wire [6:0] wiper_position_register
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	wire [6:0] p = wiper_position_register;
	a_tap_onehot: assert property (tap_select == 128'h1 << p)
		else $error("tap");
	a_reset_mid: assert property ($rose(nrst) |-> p == 7'h40)
		else $error("reset value");
	a_quiet_start: assert property ($rose(nrst) |-> sda_oe_n [*3])
		else $error("early drive");
	a_open_drain: assert property (sda_out == 1'b0)
		else $error("sda high");
	a_hold_high: assert property (scl_in [*4] |-> $stable(sda_oe_n))
		else $error("sda moved");
	a_drive_bound: assert property ($fell(sda_oe_n) |-> ##[1:80] $rose(sda_oe_n))
		else $error("stuck");
	a_en_freeze: assert property (!clk_en |=> $stable(p) && $stable(sda_oe_n))
		else $error("frozen");
	a_update_ack: assert property ($changed(p) |-> $fell(sda_oe_n))
		else $error("no ack");
	c_write: cover property ($changed(p));
	c_ack: cover property ($fell(sda_oe_n));
	c_freeze: cover property (!clk_en [*3]);
endmodule
bind i2c_wiper_position_register wiper_sva u_sva (.clk(clk), .nrst(nrst), .clk_en(clk_en),
	.scl_in(scl_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .tap_select(tap_select),
	.wiper_position_register(wiper_position_register));
`default_nettype wire

// ==== testbench/i2c_host.sv ====
`timescale 1ns/10ps
`default_nettype none
module i2c_host (
	// Bus, sda_m high releases
	output logic scl = 1'b1,
	output logic sda_m = 1'b1,
	input wire logic sda
);
	logic [8:0] r;
	// Start (1,0,0), stop (0,1,1); long rest lets the slave release
	task automatic cond(input logic a, b, c);
		#60 sda_m = a;
		#20 scl = 1'b1;
		#20 sda_m = b;
		#20 scl = c;
	endtask
	task automatic xfer(input logic [8:0] w);
		for (int i = 8; i >= 0; i--) begin
			#20 sda_m = w[i];
			#20 scl = 1'b1;
			#20 r[i] = sda;
			#20 scl = 1'b0;
		end
	endtask
	task automatic head(input logic [6:0] id, input logic [7:0] ix, output logic [2:0] a);
		cond(1'b1, 1'b0, 1'b0);
		xfer({id, 2'b01});
		a[2] = !r[0];
		xfer({ix, 1'b1});
		a[1] = !r[0];
	endtask
	task automatic wr(input logic [6:0] id, input logic [7:0] ix, d, output logic [2:0] a);
		head(id, ix, a);
		xfer({d, 1'b1});
		a[0] = !r[0];
		cond(1'b0, 1'b1, 1'b1);
	endtask
	task automatic rd(input logic [6:0] id, output logic [2:0] a, output logic [7:0] d);
		head(id, 8'h00, a);
		cond(1'b1, 1'b0, 1'b0);
		xfer({id, 2'b11});
		a[0] = !r[0];
		xfer(9'h1ff);
		d = r[8:1];
		cond(1'b0, 1'b1, 1'b1);
	endtask
	task automatic rd2(input logic [6:0] id, output logic [2:0] a, output logic [7:0] d, e);
		head(id, 8'h00, a);
		cond(1'b1, 1'b0, 1'b0);
		xfer({id, 2'b11});
		a[0] = !r[0];
		xfer(9'h1fe);
		d = r[8:1];
		xfer(9'h1ff);
		e = r[8:1];
		cond(1'b0, 1'b1, 1'b1);
	endtask
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "wiper_defines.vh"
module tb_top;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic clk_en = 1'b1;
	logic [2:0] a;
	logic [7:0] d, v, d2;
	wire scl, sda_m, sda, sda_out, sda_oe_n;
	wire [127:0] tap;
	wire [6:0] pos;
	int n_errors = 0;
	int num_checks = 0;
	int cyc = 0;
	// Pull-up: released line reads high
	assign sda = sda_m & (sda_oe_n | sda_out);
	always #5 clk = ~clk;
	i2c_host m (.scl(scl), .sda_m(sda_m), .sda(sda));
	i2c_wiper_position_register dut (.clk(clk), .nrst(nrst), .clk_en(clk_en), .scl_in(scl),
		.sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .tap_select(tap),
		.wiper_position_register(pos));
	task chk(input logic [127:0] s, e);
		num_checks++;
		if (s !== e) begin
			n_errors++;
			$display("[ERR] %0t %h %h", $time, s, e);
		end
	endtask
	function logic [7:0] rd_exp(input logic [7:0] w);
		return {1'b0, w[6:0]};
	endfunction
	task end_sim;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			end_sim;
		end
	end
	initial begin
		void'($urandom(32'haf48_6672));
		repeat (8) @(posedge clk);
		#1 nrst = 1'b1;
		repeat (4) @(posedge clk);
		#1 chk(pos, 7'h40);
		for (int i = 0; i < 10; i++) begin
			v = i == 0 ? 8'hff : i == 1 ? 8'h00 : 8'($urandom);
			m.wr(`DEVICE_ID, 8'h00, v, a);
			chk(a, 3'b111);
			chk(tap, 128'h1 << v[6:0]);
			m.rd(`DEVICE_ID, a, d);
			chk(a, 3'b111);
			chk(d, rd_exp(v));
			clk_en = 1'b0;
			repeat (1 + $urandom % 4) @(posedge clk);
			#1 clk_en = 1'b1;
		end
		$display("write and read done");
		m.wr(`DEVICE_ID ^ 7'h01, 8'h00, 8'h15, a);
		chk(a, 3'b000);
		m.wr(`DEVICE_ID, 8'h01, 8'h15, a);
		chk({a, pos}, {3'b100, v[6:0]});
		$display("refusals done");
		m.rd2(`DEVICE_ID, a, d, d2);
		chk(a, 3'b111);
		chk({d, d2}, {rd_exp(v), rd_exp(v)});
		$display("repeated read done");
		nrst = 1'b0;
		#20 nrst = 1'b1;
		m.rd(`DEVICE_ID, a, d);
		chk(d, 8'h40);
		$display("second reset done");
		end_sim;
	end
endmodule
`default_nettype wire
